// ### verilog/gxc_map.vh
`ifndef GXC_MAP_VH
`define GXC_MAP_VH
// register select codes, low three bits of the pointer
`define GXC_REG_PIN_LEVEL0   3'h0
`define GXC_REG_PIN_LEVEL1   3'h1
`define GXC_REG_DRIVE_LEVEL0 3'h2
`define GXC_REG_DRIVE_LEVEL1 3'h3
`define GXC_REG_INVERT0      3'h4
`define GXC_REG_INVERT1      3'h5
`define GXC_REG_DIRECTION0   3'h6
`define GXC_REG_DIRECTION1   3'h7
// reset values
`define GXC_RST_DRIVE_LEVEL  8'hFF
`define GXC_RST_INVERT       8'h00
`define GXC_RST_DIRECTION    8'hFF
// fixed upper four bits of the seven-bit slave address (arbitrary value)
`define GXC_ADDR_FIXED       4'h4
// direction bit of the address byte
`define GXC_DIR_READ         1'b1
`endif

// ### verilog/gxc_expander.v
// Summary of operation
// - slave address low three bits come from the three address-select pins
// - address byte last bit one means read, zero means write
// - first byte after acknowledged address is latched into write-only pointer
// - pointer low three bits pick input, output, invert or direction register
// - input register bits show current pin level regardless of direction
// - writes to input registers are ignored, only the pointer low bit still toggles
// - output bit drives pin only when pin is an output
// - output register reads return written value, not pin level
// - reset loads outputs ff, invert 00, direction ff, serial machine idle
// - invert bit one presents inverted pin level in input register
// - direction one is high-impedance input, zero is driven output
// - output pin enables high or low driver per output bit, input none
// - alert asserts on any transition of an input-configured pin
// - alert clears when pin returns to original value or port read
// - read clear happens at the acknowledge bit after its rising clock edge
// - a change inside the clearing acknowledge pulse may be lost
// - after clearing, later input changes raise the alert again
// - output-configured pins never cause the alert
// - turning an output into an input may raise a spurious alert
// - alert is active low open-drain, drives low only when asserted
// - successive data bytes alternate between the two registers of a pair
`timescale 1ns/10ps
`default_nettype none
`include "gxc_map.vh"
module gxc_expander #(
   parameter PORT_W = 8
) (
   input  wire                  i_sys_clk,
   input  wire                  i_sys_rst,
   input  wire                  i_clk_en,
   input  wire                  i_scl,
   input  wire                  i_sda,
   output reg                   o_sda_oe,
   output reg                   o_sda_out,
   input  wire                  i_addr_select_bit0,
   input  wire                  i_addr_select_bit1,
   input  wire                  i_addr_select_bit2,
   input  wire [PORT_W-1:0]     i_port0_pin,
   input  wire [PORT_W-1:0]     i_port1_pin,
   output reg  [PORT_W-1:0]     o_port0_pin_out,
   output reg  [PORT_W-1:0]     o_port0_pin_oe,
   output reg  [PORT_W-1:0]     o_port1_pin_out,
   output reg  [PORT_W-1:0]     o_port1_pin_oe,
   output reg                   o_alert_out,
   output reg                   o_alert_oe
);
   ////////////////////////////////////////////////////////////////////////////
   // synchronisers: first stage is read only by the second
   reg [1:0]          scl_sync;
   reg [1:0]          sda_sync;
   reg [2:0]          addr_s1;
   reg [2:0]          addr_s2;
   reg [2*PORT_W-1:0] pin_s1;
   reg [2*PORT_W-1:0] pin_s2;
   reg                scl_d;
   reg                sda_d;
   always @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         addr_s1  <= 3'h0;
         addr_s2  <= 3'h0;
         pin_s1   <= {2*PORT_W{1'b0}};
         pin_s2   <= {2*PORT_W{1'b0}};
         scl_d    <= 1'b1;
         sda_d    <= 1'b1;
      end else if (i_clk_en) begin
         scl_sync <= {scl_sync[0], i_scl};
         sda_sync <= {sda_sync[0], i_sda};
         addr_s1  <= {i_addr_select_bit2, i_addr_select_bit1, i_addr_select_bit0};
         addr_s2  <= addr_s1;
         pin_s1   <= {i_port1_pin, i_port0_pin};
         pin_s2   <= pin_s1;
         scl_d    <= scl_sync[1];
         sda_d    <= sda_sync[1];
      end
   end
   wire scl     = scl_sync[1];
   wire sda     = sda_sync[1];
   wire scl_ris = scl & ~scl_d;
   wire scl_fal = ~scl & scl_d;
   wire start_c = scl & scl_d & sda_d & ~sda;
   wire stop_c  = scl & scl_d & ~sda_d & sda;

   ////////////////////////////////////////////////////////////////////////////
   // registers and pin-level view
   reg [PORT_W-1:0] drive_level_port0;
   reg [PORT_W-1:0] drive_level_port1;
   reg [PORT_W-1:0] invert_port0;
   reg [PORT_W-1:0] invert_port1;
   reg [PORT_W-1:0] direction_port0;
   reg [PORT_W-1:0] direction_port1;
   reg [7:0]        register_select_pointer;
   // input register follows the pin whatever the direction, after inversion
   wire [PORT_W-1:0] pin_level_port0 = pin_s2[PORT_W-1:0] ^ invert_port0;
   wire [PORT_W-1:0] pin_level_port1 = pin_s2[2*PORT_W-1:PORT_W] ^ invert_port1;

   // read multiplexer on the low three pointer bits
   reg [PORT_W-1:0] rd_data;
   always @* begin
      case (register_select_pointer[2:0])
         `GXC_REG_PIN_LEVEL0:   rd_data = pin_level_port0;
         `GXC_REG_PIN_LEVEL1:   rd_data = pin_level_port1;
         `GXC_REG_DRIVE_LEVEL0: rd_data = drive_level_port0;
         `GXC_REG_DRIVE_LEVEL1: rd_data = drive_level_port1;
         `GXC_REG_INVERT0:      rd_data = invert_port0;
         `GXC_REG_INVERT1:      rd_data = invert_port1;
         `GXC_REG_DIRECTION0:   rd_data = direction_port0;
         default:               rd_data = direction_port1;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // serial slave state machine
   localparam ST_IDLE = 3'h0;
   localparam ST_ADDR = 3'h1;
   localparam ST_AACK = 3'h2;
   localparam ST_WBYT = 3'h3;
   localparam ST_WACK = 3'h4;
   localparam ST_RBYT = 3'h5;
   localparam ST_RACK = 3'h6;
   reg [2:0] state;
   reg [3:0] bit_cnt;
   reg [7:0] shreg;
   reg       is_read;
   reg       have_cmd;
   reg       rd_clear0;
   reg       rd_clear1;
   wire [6:0] my_addr = {`GXC_ADDR_FIXED, addr_s2};

   always @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state                   <= ST_IDLE;
         bit_cnt                 <= 4'h0;
         shreg                   <= 8'h00;
         is_read                 <= 1'b0;
         have_cmd                <= 1'b0;
         rd_clear0               <= 1'b0;
         rd_clear1               <= 1'b0;
         o_sda_oe                <= 1'b0;
         o_sda_out               <= 1'b0;
         register_select_pointer <= 8'h00;
         drive_level_port0       <= `GXC_RST_DRIVE_LEVEL;
         drive_level_port1       <= `GXC_RST_DRIVE_LEVEL;
         invert_port0            <= `GXC_RST_INVERT;
         invert_port1            <= `GXC_RST_INVERT;
         direction_port0         <= `GXC_RST_DIRECTION;
         direction_port1         <= `GXC_RST_DIRECTION;
      end else if (i_clk_en) begin
         rd_clear0 <= 1'b0;
         rd_clear1 <= 1'b0;
         if (start_c) begin
            state    <= ST_ADDR;
            bit_cnt  <= 4'h0;
            o_sda_oe <= 1'b0;
         end else if (stop_c) begin
            state    <= ST_IDLE;
            o_sda_oe <= 1'b0;
         end else begin
            case (state)
               ST_IDLE: begin
                  o_sda_oe <= 1'b0;
               end
               ST_ADDR: begin
                  if (scl_ris) begin
                     shreg   <= {shreg[6:0], sda};
                     bit_cnt <= bit_cnt + 4'h1;
                  end else if (scl_fal && bit_cnt == 4'h8) begin
                     if (shreg[7:1] == my_addr) begin
                        is_read  <= (shreg[0] == `GXC_DIR_READ);
                        have_cmd <= 1'b0;
                        o_sda_oe <= 1'b1;
                        state    <= ST_AACK;
                     end else begin
                        state <= ST_IDLE;
                     end
                  end
               end
               ST_AACK: begin
                  if (scl_fal) begin
                     bit_cnt <= 4'h0;
                     if (is_read) begin
                        shreg     <= rd_data;
                        o_sda_oe  <= ~rd_data[7];
                        state     <= ST_RBYT;
                     end else begin
                        o_sda_oe <= 1'b0;
                        state    <= ST_WBYT;
                     end
                  end
               end
               ST_WBYT: begin
                  if (scl_ris) begin
                     shreg   <= {shreg[6:0], sda};
                     bit_cnt <= bit_cnt + 4'h1;
                  end else if (scl_fal && bit_cnt == 4'h8) begin
                     o_sda_oe <= 1'b1;
                     state    <= ST_WACK;
                     if (!have_cmd) begin
                        register_select_pointer <= shreg;
                        have_cmd                <= 1'b1;
                     end else begin
                        // input registers are not writable: nothing stored
                        case (register_select_pointer[2:0])
                           `GXC_REG_DRIVE_LEVEL0: drive_level_port0 <= shreg;
                           `GXC_REG_DRIVE_LEVEL1: drive_level_port1 <= shreg;
                           `GXC_REG_INVERT0:      invert_port0      <= shreg;
                           `GXC_REG_INVERT1:      invert_port1      <= shreg;
                           `GXC_REG_DIRECTION0:   direction_port0   <= shreg;
                           `GXC_REG_DIRECTION1:   direction_port1   <= shreg;
                           default:               shreg             <= shreg;
                        endcase
                        register_select_pointer[0] <= ~register_select_pointer[0];
                     end
                  end
               end
               ST_WACK: begin
                  if (scl_fal) begin
                     o_sda_oe <= 1'b0;
                     bit_cnt  <= 4'h0;
                     state    <= ST_WBYT;
                  end
               end
               ST_RBYT: begin
                  if (scl_fal) begin
                     if (bit_cnt == 4'h7) begin
                        o_sda_oe <= 1'b0;
                        state    <= ST_RACK;
                     end else begin
                        o_sda_oe <= ~shreg[6];
                        shreg    <= {shreg[6:0], 1'b0};
                        bit_cnt  <= bit_cnt + 4'h1;
                     end
                  end
               end
               ST_RACK: begin
                  if (scl_ris) begin
                     // clear the alert of the port just read, at the ack clock
                     rd_clear0 <= (register_select_pointer[2:0] == `GXC_REG_PIN_LEVEL0);
                     rd_clear1 <= (register_select_pointer[2:0] == `GXC_REG_PIN_LEVEL1);
                     register_select_pointer[0] <= ~register_select_pointer[0];
                     if (sda)
                        state <= ST_IDLE;
                  end else if (scl_fal) begin
                     bit_cnt  <= 4'h0;
                     shreg    <= rd_data;
                     o_sda_oe <= ~rd_data[7];
                     state    <= ST_RBYT;
                  end
               end
               default: state <= ST_IDLE;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin drivers and change alert, per bit
   reg [PORT_W-1:0] snap0;
   reg [PORT_W-1:0] snap1;
   reg [2:0]        snap_wait;
   wire             snap_valid = snap_wait[2];
   wire [PORT_W-1:0] diff0;
   wire [PORT_W-1:0] diff1;
   genvar g;
   generate
      for (g = 0; g < PORT_W; g = g + 1) begin : g_bit
         // only input pins compare, so output pins never alert
         assign diff0[g] = direction_port0[g] & (pin_level_port0[g] ^ snap0[g]);
         assign diff1[g] = direction_port1[g] & (pin_level_port1[g] ^ snap1[g]);
      end
   endgenerate

   always @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_port0_pin_out <= {PORT_W{1'b0}};
         o_port0_pin_oe  <= {PORT_W{1'b0}};
         o_port1_pin_out <= {PORT_W{1'b0}};
         o_port1_pin_oe  <= {PORT_W{1'b0}};
         o_alert_out     <= 1'b0;
         o_alert_oe      <= 1'b0;
         snap0           <= {PORT_W{1'b0}};
         snap1           <= {PORT_W{1'b0}};
         snap_wait       <= 3'h0;
      end else if (i_clk_en) begin
         // high or low driver chosen by the output bit; none when an input
         o_port0_pin_oe  <= ~direction_port0;
         o_port1_pin_oe  <= ~direction_port1;
         o_port0_pin_out <= drive_level_port0;
         o_port1_pin_out <= drive_level_port1;
         // first snapshot waits until both synchroniser stages hold real pin
         // levels, else a power-up alert would follow every reset
         snap_wait <= {snap_wait[1:0], 1'b1};
         if (!snap_valid || rd_clear0)
            snap0 <= pin_level_port0;
         if (!snap_valid || rd_clear1)
            snap1 <= pin_level_port1;
         // a pin back at its snapshot drops the alert; a stale snapshot after a
         // direction change may alert falsely, as the part is meant to behave
         o_alert_oe  <= snap_valid & ~(rd_clear0 | rd_clear1) & (|diff0 | |diff1);
         o_alert_out <= 1'b0;
      end
   end
endmodule // gxc_expander
`default_nettype wire

// ### verification/gxc_bus_master.sv
`timescale 1ns/10ps
`default_nettype none
// serial master model: both lines released and the clock still between frames
module gxc_bus_master (
   input  wire logic i_sys_clk,
   input  wire logic i_sda,
   output var logic  o_scl = 1'b1,
   output var logic  o_sda_low = 1'b0
);
   task automatic wt(input int n);
      repeat (n) @(posedge i_sys_clk);
   endtask
   // a quarter of the 128 ns bit, nearest whole-cycle fit to 125 ns
   task automatic step(input logic c, input logic d);
      wt(4);
      o_scl <= c;
      o_sda_low <= d;
   endtask
   // start or repeated start: data falls while the clock is high
   task automatic start();
      step(o_scl, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
      step(1'b0, 1'b1);
   endtask
   // stop: data rises while the clock is high
   task automatic stop();
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
      wt(8);
   endtask
   // nine bits msb first; data moves only while the clock is low
   task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         step(1'b0, ~tx[i]);
         step(1'b1, ~tx[i]);
         wt(4);
         rx[i] = i_sda;
         step(1'b0, ~tx[i]);
      end
   endtask
endmodule // gxc_bus_master
`default_nettype wire

// ### verification/gxc_expander_sva.sv
`timescale 1ns/10ps
`default_nettype none
module gxc_expander_chk #(
   parameter PORT_W = 8
) (
   input wire logic              i_sys_clk,
   input wire logic              i_sys_rst,
   input wire logic              i_scl,
   input wire logic [PORT_W-1:0] i_port0_pin,
   input wire logic [PORT_W-1:0] i_port1_pin,
   input wire logic              o_sda_oe,
   input wire logic [PORT_W-1:0] o_port0_pin_oe,
   input wire logic [PORT_W-1:0] o_port1_pin_oe,
   input wire logic              o_alert_out,
   input wire logic              o_alert_oe
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_sys_rst);
   // both ports side by side
   wire [2*PORT_W-1:0] pin = {i_port0_pin, i_port1_pin};
   wire [2*PORT_W-1:0] oe  = {o_port0_pin_oe, o_port1_pin_oe};
   // an input pin moves while directions hold and the alert is quiet
   sequence in_pin_moves;
      ((pin ^ $past(pin)) & ~oe) != 0 && $stable(oe) && !o_alert_oe;
   endsequence
   // sda is taken while the clock is low and then held
   sequence sda_held;
      !i_scl ##1 o_sda_oe [*4];
   endsequence
   ////////////////////////////////////////////////////////////
   alert_raise_a: assert property (in_pin_moves |-> ##[1:8] o_alert_oe)
      else $error("alert missed an input change");
   alert_drop_a: assert property ($fell(o_alert_oe) |-> i_scl || pin != $past(pin, 8))
      else $error("alert dropped without read or return");
   out_quiet_a: assert property ((&oe) [*8] |-> !$rose(o_alert_oe))
      else $error("alert raised with every pin driven");
   alert_od_a: assert property (!o_alert_out)
      else $error("alert line driven high");
   rst_idle_a: assert property ($fell(i_sys_rst) |-> !o_sda_oe && !o_alert_oe && oe == 0)
      else $error("not idle after reset");
   sda_take_a: assert property ($rose(o_sda_oe) |-> sda_held)
      else $error("sda pulled at the wrong time");
   sda_give_a: assert property ($fell(o_sda_oe) |-> !i_scl)
      else $error("sda released while clock high");
   dir_sync_a: assert property ($changed(oe) |-> !i_scl)
      else $error("direction moved outside a byte end");
endmodule // gxc_expander_chk
bind gxc_expander gxc_expander_chk #(.PORT_W(PORT_W)) chk_inst (
   .i_sys_clk, .i_sys_rst, .i_scl, .i_port0_pin, .i_port1_pin, .o_sda_oe,
   .o_port0_pin_oe, .o_port1_pin_oe, .o_alert_out, .o_alert_oe);
`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin err_count++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module tb_top;
   logic        i_sys_clk = 1'b0;
   logic        i_sys_rst = 1'b1;
   logic        scl, sda_low;
   logic [7:0]  ext0 = 8'hFF, ext1 = 8'hFF;
   logic [15:0] q;
   logic [8:0]  r;
   int          err_count = 0, cmp_count = 0;
   wire         o_sda_oe, o_alert_oe, o_sda_out, o_alert_out;
   wire  [7:0]  o_port0_pin_out, o_port0_pin_oe, o_port1_pin_out, o_port1_pin_oe;
   // pulled-up open-drain lines; a pin follows the device only where it drives
   wire         sda = ~sda_low & (o_sda_oe ? o_sda_out : 1'b1);
   wire         alert_n = o_alert_oe ? o_alert_out : 1'b1;
   wire  [7:0]  p0 = (o_port0_pin_oe & o_port0_pin_out) | (~o_port0_pin_oe & ext0);
   wire  [7:0]  p1 = (o_port1_pin_oe & o_port1_pin_out) | (~o_port1_pin_oe & ext1);
   // 125 MHz system clock
   always #4 i_sys_clk = ~i_sys_clk;
   ////////////////////////////////////////////////////////////
   // straps at 101; enable held on, so a frozen core is not exercised
   gxc_expander gxc_expander_inst (
      .i_sys_clk, .i_sys_rst, .i_clk_en(1'b1), .i_scl(scl), .i_sda(sda), .o_sda_oe, .o_sda_out,
      .i_addr_select_bit0(1'b1), .i_addr_select_bit1(1'b0), .i_addr_select_bit2(1'b1),
      .i_port0_pin(p0), .i_port1_pin(p1), .o_port0_pin_out, .o_port0_pin_oe,
      .o_port1_pin_out, .o_port1_pin_oe, .o_alert_out, .o_alert_oe);
   gxc_bus_master bm (
      .i_sys_clk, .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
   // one pair access: pointer write, then two data bytes out or back
   task automatic acc(input logic rnw, input logic [7:0] p, input logic [15:0] d, output logic [15:0] v);
      logic [8:0] a, b, c, x, y;
      c = 9'h0;
      bm.start();
      bm.xfer({8'h4A, 1'b1}, a);
      bm.xfer({p, 1'b1}, b);
      if (rnw) begin
         bm.start();
         bm.xfer({8'h4B, 1'b1}, c);
      end
      bm.xfer({rnw ? 8'hFF : d[15:8], ~rnw}, x);
      bm.xfer({rnw ? 8'hFF : d[7:0], 1'b1}, y);
      bm.stop();
      v = {x[8:1], y[8:1]};
      `CHK("ack bits", 5'h00, {a[0], b[0], c[0], x[0], y[0] ^ rnw})
   endtask
   task automatic rdc(input logic [7:0] p, input logic [15:0] e);
      logic [15:0] v;
      acc(1'b1, p, 16'h0000, v);
      `CHK("register pair", e, v)
   endtask
   // move the outside pin levels and look at the alert line once it settles
   task automatic pins(input logic [7:0] a, input logic [7:0] b, input logic e);
      ext0 <= a;
      ext1 <= b;
      repeat (12) @(posedge i_sys_clk);
      `CHK("alert line", e, alert_n)
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (20) @(posedge i_sys_clk);
      i_sys_rst <= 1'b0;
      repeat (8) @(posedge i_sys_clk);
      `CHK("pin oe", 16'h0000, {o_port0_pin_oe, o_port1_pin_oe})
      `CHK("alert line", 1'b1, alert_n)
      rdc(8'h02, 16'hFFFF);
      rdc(8'h04, 16'h0000);
      rdc(8'h07, 16'hFFFF);
      bm.start();
      bm.xfer({8'h48, 1'b1}, r);
      bm.stop();
      `CHK("foreign ack", 1'b1, r[0])
      ext0 <= 8'hA5;
      ext1 <= 8'h3C;
      rdc(8'h00, 16'hA53C);
      acc(1'b0, 8'h00, 16'h0000, q);
      rdc(8'h00, 16'hA53C);
      rdc(8'h02, 16'hFFFF);
      acc(1'b0, 8'h04, 16'hFF0F, q);
      rdc(8'h05, 16'h0FFF);
      rdc(8'h00, 16'h5A33);
      acc(1'b0, 8'h04, 16'h0000, q);
      rdc(8'h01, 16'h3CA5);
      pins(8'hA5, 8'h3C, 1'b1);
      pins(8'hA4, 8'h3C, 1'b0);
      pins(8'hA5, 8'h3C, 1'b1);
      pins(8'hA5, 8'h3D, 1'b0);
      rdc(8'h00, 16'hA53D);
      `CHK("alert line", 1'b1, alert_n)
      acc(1'b0, 8'h02, 16'h5AC3, q);
      acc(1'b0, 8'h06, 16'h0FF0, q);
      `CHK("pin oe", 16'hF00F, {o_port0_pin_oe, o_port1_pin_oe})
      `CHK("driven pins", 16'h5003, {p0 & o_port0_pin_oe, p1 & o_port1_pin_oe})
      rdc(8'h03, 16'hC35A);
      rdc(8'h00, 16'h5533);
      acc(1'b0, 8'h06, 16'h0000, q);
      acc(1'b0, 8'h02, 16'hFF00, q);
      pins(8'hA5, 8'h3D, 1'b1);
      rdc(8'h00, 16'hFF00);
      results();
   end
   // watchdog well past the roughly 15k cycles the sequence needs
   initial begin
      repeat (60000) @(posedge i_sys_clk);
      err_count++;
      results();
   end
endmodule // tb_top
`default_nettype wire
